// ---- rtl/timer16_pkg.sv ----
`default_nettype none
package timer16_pkg;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int COUNT_W = 16;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] CAPCMP_RST = 16'h0000;
  localparam logic [1:0] FILTER_RST = 2'h0;

  // ****************************************************************
  // run mode pair {hi, lo}
  // ****************************************************************
  typedef enum logic [1:0] {
    RUN_STOP = 2'b00,
    RUN_FREE = 2'b01,
    RUN_CLR_PIN = 2'b10,
    RUN_CLR_MATCH = 2'b11
  } run_mode_e;

  // ****************************************************************
  // valid edge selection
  // ****************************************************************
  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_e;

  // ****************************************************************
  // output preset pair {high, low}
  // ****************************************************************
  localparam logic [1:0] PRESET_HOLD = 2'b00;
  localparam logic [1:0] PRESET_LOW = 2'b01;
  localparam logic [1:0] PRESET_HIGH = 2'b10;

endpackage : timer16_pkg
`default_nettype wire

// ---- rtl/edge_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_filter
  import timer16_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pinIn,
  input wire logic sampleEn,
  output logic riseDet,
  output logic fallDet
);

  // ****************************************************************
  // two-flop synchroniser; first flop read only by the second
  // ****************************************************************
  logic syncA_r;
  logic syncB_r;
  logic [1:0] hist_r;
  logic [1:0] hist_nxt;
  logic stable_r;
  logic stable_nxt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
    end else begin
      syncA_r <= pinIn;
      syncB_r <= syncA_r;
    end
  end

  // a level counts only when seen on two sample ticks in a row, which
  // rejects short noise; stable level resets low so a pin held high
  // at the first start is seen as a rising edge, but not after a stop
  always_comb begin
    hist_nxt = hist_r;
    stable_nxt = stable_r;
    riseDet = 1'b0;
    fallDet = 1'b0;
    if (sampleEn) begin
      hist_nxt = {hist_r[0], syncB_r};
      if (hist_nxt == 2'b11 && !stable_r) begin
        stable_nxt = 1'b1;
        riseDet = 1'b1;
      end else if (hist_nxt == 2'b00 && stable_r) begin
        stable_nxt = 1'b0;
        fallDet = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_r <= FILTER_RST;
      stable_r <= 1'b0;
    end else begin
      hist_r <= hist_nxt;
      stable_r <= stable_nxt;
    end
  end

endmodule : edge_filter
`default_nettype wire

// ---- rtl/timer16_capture_compare.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - selected trigger edge loads count into first register
// - primary pin edge loads count into second register
// - reverse-edge capture raises no first interrupt
// - preset 00 hold, 01 low, 10 high
// - start counting from last preset level
// - first match interrupt inverts output
// - first match may slip one count clock
// - capture proceeds during read; read after interrupt
// - register contents undefined after stop
// - wrap flag also set on FFFFH match clear
// - flag clear before count 0001H is ignored
// - capture on falling phase, interrupt next rise
module timer16_capture_compare
  import timer16_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic countTick,
  input wire logic primaryTriggerPin,
  input wire logic secondaryTriggerPin,
  input wire logic runModeBitHi,
  input wire logic runModeBitLo,
  input wire logic [1:0] primaryEdgeSel,
  input wire logic [1:0] secondaryEdgeSel,
  input wire logic firstCaptureMode,
  input wire logic firstReverseSrc,
  input wire logic secondCaptureMode,
  input wire logic cmpWriteFirst,
  input wire logic cmpWriteSecond,
  input wire logic [15:0] cmpWriteData,
  input wire logic outEnable,
  input wire logic firstMatchToggleEn,
  input wire logic secondMatchToggleEn,
  input wire logic outPresetHigh,
  input wire logic outPresetLow,
  input wire logic wrapClear,
  output logic [15:0] mainCount,
  output logic [15:0] firstCapCmp,
  output logic [15:0] secondCapCmp,
  output logic timerOutPin,
  output logic firstMatchIrq,
  output logic secondMatchIrq,
  output logic wrapFlag
);

  // ****************************************************************
  // mode decode and pin edge detection
  // ****************************************************************
  run_mode_e runMode;
  logic running;
  logic priRise;
  logic priFall;
  logic secRise;
  logic secFall;
  logic priValid;
  logic priReverse;
  logic secValid;

  assign runMode = run_mode_e'({runModeBitHi, runModeBitLo});
  assign running = (runMode != RUN_STOP);

  // pins are sampled on the count clock, so edges land on tick cycles
  edge_filter priFilter (
    .clk(clk),
    .rst(rst),
    .pinIn(primaryTriggerPin),
    .sampleEn(countTick),
    .riseDet(priRise),
    .fallDet(priFall)
  );

  edge_filter secFilter (
    .clk(clk),
    .rst(rst),
    .pinIn(secondaryTriggerPin),
    .sampleEn(countTick),
    .riseDet(secRise),
    .fallDet(secFall)
  );

  // edges are not acknowledged while the timer is stopped
  always_comb begin
    priValid = 1'b0;
    priReverse = 1'b0;
    secValid = 1'b0;
    case (edge_sel_e'(primaryEdgeSel))
      EDGE_FALL: begin
        priValid = priFall;
        priReverse = priRise;
      end
      EDGE_RISE: begin
        priValid = priRise;
        priReverse = priFall;
      end
      EDGE_BOTH: begin
        priValid = priRise | priFall;
        priReverse = priRise | priFall;
      end
      default: begin
        priValid = 1'b0;
        priReverse = 1'b0;
      end
    endcase
    case (edge_sel_e'(secondaryEdgeSel))
      EDGE_FALL: secValid = secFall;
      EDGE_RISE: secValid = secRise;
      EDGE_BOTH: secValid = secRise | secFall;
      default: secValid = 1'b0;
    endcase
    priValid = priValid & running;
    priReverse = priReverse & running;
    secValid = secValid & running;
  end

  // ****************************************************************
  // main counter and wrap flag
  // ****************************************************************
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic wrap_r;
  logic wrap_nxt;
  logic wrapHold_r;
  logic wrapHold_nxt;
  logic wrapSet;
  logic firstMatch;
  logic secondMatch;
  // compare values are read by the counter, so they are declared here
  logic [15:0] firstCapCmp_r;
  logic [15:0] secondCapCmp_r;

  assign firstMatch = countTick && !firstCaptureMode && (count_r == firstCapCmp_r);
  assign secondMatch = countTick && !secondCaptureMode && (count_r == secondCapCmp_r);

  // counting starts on the first tick after the mode write; the tick
  // phase is free running, hence up to one count clock of start error
  always_comb begin
    count_nxt = count_r;
    wrapSet = 1'b0;
    wrapHold_nxt = wrapHold_r;
    if (!running) begin
      count_nxt = COUNT_RST;
      wrapHold_nxt = 1'b0;
    end else if (countTick) begin
      wrapHold_nxt = 1'b0;
      if (runMode == RUN_CLR_PIN && priValid) begin
        count_nxt = COUNT_RST;
      end else if (runMode == RUN_CLR_MATCH && count_r == firstCapCmp_r) begin
        count_nxt = COUNT_RST;
        if (firstCapCmp_r == COUNT_MAX) begin
          wrapSet = 1'b1;
          wrapHold_nxt = 1'b1;
        end
      end else if (count_r == COUNT_MAX) begin
        count_nxt = COUNT_RST;
        wrapSet = 1'b1;
        wrapHold_nxt = 1'b1;
      end else begin
        count_nxt = count_r + 16'h0001;
      end
    end
    // a clear while the count still sits at zero after a wrap is lost,
    // and a set in the same cycle as a clear always wins
    wrap_nxt = wrapSet | (wrap_r & ~(wrapClear & ~wrapHold_r));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= COUNT_RST;
      wrap_r <= 1'b0;
      wrapHold_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      wrap_r <= wrap_nxt;
      wrapHold_r <= wrapHold_nxt;
    end
  end

  // ****************************************************************
  // capture/compare registers
  // ****************************************************************
  logic [15:0] firstCapCmp_nxt;
  logic [15:0] secondCapCmp_nxt;
  logic capFirstReq_r;
  logic capFirstReq_nxt;
  logic capFirstIrq_r;
  logic capFirstIrq_nxt;
  logic capSecondReq_r;
  logic capSecondReq_nxt;
  logic extFirstIrq;

  // edges found on a tick (rising phase) are captured one cycle later,
  // standing in for the falling phase of the count clock
  always_comb begin
    capFirstReq_nxt = 1'b0;
    capFirstIrq_nxt = capFirstIrq_r;
    capSecondReq_nxt = 1'b0;
    extFirstIrq = 1'b0;
    if (firstCaptureMode) begin
      if (firstReverseSrc) begin
        capFirstReq_nxt = priReverse;
        extFirstIrq = secValid; // secondary edge: interrupt only, no load
      end else begin
        capFirstReq_nxt = secValid;
      end
    end
    if (secondCaptureMode) begin
      capSecondReq_nxt = priValid;
    end
    if (capFirstReq_r) begin
      capFirstIrq_nxt = !firstReverseSrc;
    end else if (countTick) begin
      capFirstIrq_nxt = 1'b0;
    end
  end

  // a capture always lands even if software reads at that moment; the
  // registers simply hold after a stop and carry no defined meaning then
  always_comb begin
    firstCapCmp_nxt = firstCapCmp_r;
    secondCapCmp_nxt = secondCapCmp_r;
    if (capFirstReq_r) begin
      firstCapCmp_nxt = count_r;
    end else if (cmpWriteFirst && !firstCaptureMode) begin
      firstCapCmp_nxt = cmpWriteData;
    end
    if (capSecondReq_r) begin
      secondCapCmp_nxt = count_r;
    end else if (cmpWriteSecond && !secondCaptureMode) begin
      secondCapCmp_nxt = cmpWriteData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      firstCapCmp_r <= CAPCMP_RST;
      secondCapCmp_r <= CAPCMP_RST;
      capFirstReq_r <= 1'b0;
      capFirstIrq_r <= 1'b0;
      capSecondReq_r <= 1'b0;
    end else begin
      firstCapCmp_r <= firstCapCmp_nxt;
      secondCapCmp_r <= secondCapCmp_nxt;
      capFirstReq_r <= capFirstReq_nxt;
      capFirstIrq_r <= capFirstIrq_nxt;
      capSecondReq_r <= capSecondReq_nxt;
    end
  end

  // ****************************************************************
  // interrupts and timer output
  // ****************************************************************
  logic pendFirst_r;
  logic pendFirst_nxt;
  logic pendSecond_r;
  logic pendSecond_nxt;
  logic firstIrq_r;
  logic firstIrq_nxt;
  logic secondIrq_r;
  logic secondIrq_nxt;
  logic out_r;
  logic out_nxt;

  // capture interrupts wait for the next tick (next rising phase)
  always_comb begin
    pendFirst_nxt = pendFirst_r;
    pendSecond_nxt = pendSecond_r;
    firstIrq_nxt = 1'b0;
    secondIrq_nxt = 1'b0;
    if (capFirstReq_r && !firstReverseSrc) begin
      pendFirst_nxt = 1'b1;
    end
    if (capSecondReq_r) begin
      pendSecond_nxt = 1'b1;
    end
    if (countTick) begin
      firstIrq_nxt = firstMatch | pendFirst_r | extFirstIrq;
      secondIrq_nxt = secondMatch | pendSecond_r;
      pendFirst_nxt = 1'b0;
      pendSecond_nxt = 1'b0;
    end
    if (!running) begin
      firstIrq_nxt = 1'b0;
      secondIrq_nxt = 1'b0;
      pendFirst_nxt = 1'b0;
      pendSecond_nxt = 1'b0;
    end
  end

  // presets act only while stopped; the level kept then is where the
  // output starts once counting begins
  always_comb begin
    out_nxt = out_r;
    if (!running) begin
      if ({outPresetHigh, outPresetLow} == PRESET_HIGH) begin
        out_nxt = 1'b1;
      end else if ({outPresetHigh, outPresetLow} == PRESET_LOW) begin
        out_nxt = 1'b0;
      end
    end else if (outEnable) begin
      if (firstIrq_r && firstMatchToggleEn) begin
        out_nxt = ~out_nxt;
      end
      if (secondIrq_r && !secondCaptureMode && secondMatchToggleEn) begin
        out_nxt = ~out_nxt;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pendFirst_r <= 1'b0;
      pendSecond_r <= 1'b0;
      firstIrq_r <= 1'b0;
      secondIrq_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      pendFirst_r <= pendFirst_nxt;
      pendSecond_r <= pendSecond_nxt;
      firstIrq_r <= firstIrq_nxt;
      secondIrq_r <= secondIrq_nxt;
      out_r <= out_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign mainCount = count_r;
  assign firstCapCmp = firstCapCmp_r;
  assign secondCapCmp = secondCapCmp_r;
  assign timerOutPin = out_r;
  assign firstMatchIrq = firstIrq_r;
  assign secondMatchIrq = secondIrq_r;
  assign wrapFlag = wrap_r;

endmodule : timer16_capture_compare
`default_nettype wire

// ---- dv/pulse_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
  input wire logic clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic [7:0] highLen,
  output logic pinOut
);
  // ****************
  // external trigger
  // ****************
  logic [7:0] left_r;
  logic [7:0] left_nxt;
  // a fire during the high phase is dropped, never stretched
  always_comb begin
    left_nxt = left_r;
    if (left_r != 8'h00) begin
      left_nxt = left_r - 8'h01;
    end else if (fire) begin
      left_nxt = highLen;
    end
  end
  // register only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_r <= 8'h00;
    end else begin
      left_r <= left_nxt;
    end
  end
  // idles low; width kept above two count clocks so the filter takes it
  assign pinOut = (left_r != 8'h00);
endmodule : pulse_source
`default_nettype wire

// ---- dv/timer16_cc_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer16_cc_sva
  import timer16_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic countTick,
  input wire logic runModeBitHi,
  input wire logic runModeBitLo,
  input wire logic outEnable,
  input wire logic firstMatchToggleEn,
  input wire logic secondMatchToggleEn,
  input wire logic outPresetHigh,
  input wire logic outPresetLow,
  input wire logic wrapClear,
  input wire logic [15:0] mainCount,
  input wire logic timerOutPin,
  input wire logic firstMatchIrq,
  input wire logic secondMatchIrq,
  input wire logic wrapFlag
);
  // ****************
  // timer checks
  // ****************
  logic running;
  logic wrapped_r;
  logic wrapped_nxt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // any nonzero run pair counts
  assign running = runModeBitHi | runModeBitLo;
  // wrap seen, no tick since: a flag clear in this gap must not stick
  always_comb begin
    wrapped_nxt = wrapped_r;
    if (!running) begin
      wrapped_nxt = 1'b0;
    end else if (countTick) begin
      wrapped_nxt = runModeBitLo && (mainCount == COUNT_MAX);
    end
  end
  // register only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrapped_r <= 1'b0;
    end else begin
      wrapped_r <= wrapped_nxt;
    end
  end
  count_step_a: assert property (
    !runModeBitHi && runModeBitLo && countTick && mainCount != COUNT_MAX
    |=> mainCount == $past(mainCount) + 16'h0001) else $error("count did not step");
  count_hold_a: assert property (
    running && !countTick |=> $stable(mainCount)) else $error("count moved");
  stop_zero_a: assert property (
    !running |=> mainCount == COUNT_RST) else $error("count not zero");
  wrap_set_a: assert property (
    runModeBitLo && countTick && mainCount == COUNT_MAX |-> ##[1:2] wrapFlag)
    else $error("wrap flag not set");
  clear_refused_a: assert property (
    wrapped_r && wrapClear |=> wrapFlag) else $error("early clear took");
  first_toggle_a: assert property (
    firstMatchIrq && outEnable && firstMatchToggleEn && !secondMatchIrq
    |=> timerOutPin != $past(timerOutPin)) else $error("output not inverted");
  second_quiet_a: assert property (
    running && secondMatchIrq && !secondMatchToggleEn && !firstMatchIrq
    |=> $stable(timerOutPin)) else $error("output moved");
  preset_drive_a: assert property (
    !running && !$past(running) && outPresetHigh != outPresetLow && !firstMatchIrq
    && !secondMatchIrq |=> timerOutPin == $past(outPresetHigh)) else $error("preset wrong");
  start_level_a: assert property (
    !running ##1 running |=> $stable(timerOutPin)) else $error("start moved output");
endmodule : timer16_cc_sva
bind timer16_capture_compare timer16_cc_sva chk (.*);
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import timer16_pkg::*;
  // ****************
  // signals
  // ****************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic countTick = 1'b0, runModeBitHi = 1'b0, runModeBitLo = 1'b0, firePri = 1'b0;
  logic fireSec = 1'b0, firstCaptureMode = 1'b0, firstReverseSrc = 1'b0;
  logic secondCaptureMode = 1'b0, cmpWriteFirst = 1'b0, cmpWriteSecond = 1'b0;
  logic outEnable = 1'b0, wrapClear = 1'b0, firstMatchToggleEn = 1'b0;
  logic secondMatchToggleEn = 1'b0, outPresetHigh = 1'b0, outPresetLow = 1'b0;
  logic [1:0] primaryEdgeSel = 2'h0, secondaryEdgeSel = 2'h0;
  logic [15:0] cmpWriteData = 16'h0000;
  logic [15:0] mainCount, firstCapCmp, secondCapCmp;
  logic primaryTriggerPin, secondaryTriggerPin, timerOutPin;
  logic firstMatchIrq, secondMatchIrq, wrapFlag;
  int err_count = 0, samples_checked = 0, irq1Cnt = 0, irq2Cnt = 0;
  // preset rows: {high, low, expected level}
  logic [2:0] presetRows [5] = '{3'b101, 3'b001, 3'b010, 3'b000, 3'b101};
  timer16_capture_compare dut (.*);
  pulse_source priSrc (.clk, .rst, .fire(firePri), .highLen(8'h14), .pinOut(primaryTriggerPin));
  pulse_source secSrc (.clk, .rst, .fire(fireSec), .highLen(8'h14), .pinOut(secondaryTriggerPin));
  // 25 MHz
  always #20 clk = ~clk;
  // interrupt pulses are one cycle wide, so count them as they pass
  always @(posedge clk) begin
    if (firstMatchIrq === 1'b1) irq1Cnt++;
    if (secondMatchIrq === 1'b1) irq2Cnt++;
  end
  // ****************
  // tasks
  // ****************
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chkIn(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %0t got %h out of range", $time, got);
    end
  endtask : chkIn
  // one count clock every four system clocks
  task automatic ticks(input int n);
    repeat (n) begin
      countTick <= 1'b1;
      @(posedge clk);
      countTick <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : ticks
  task automatic mode(input logic [1:0] m);
    {runModeBitHi, runModeBitLo} <= m;
    repeat (2) @(posedge clk);
  endtask : mode
  task automatic clearWrap;
    wrapClear <= 1'b1;
    @(posedge clk);
    wrapClear <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : clearWrap
  task automatic wrap_up;
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk16(mainCount, COUNT_RST);
    foreach (presetRows[i]) begin
      {outPresetHigh, outPresetLow} <= presetRows[i][2:1];
      repeat (2) @(posedge clk);
      chk16(16'(timerOutPin), 16'(presetRows[i][0]));
    end
    // compare values written while stopped, and kept apart
    {outPresetHigh, outPresetLow, cmpWriteFirst} <= 3'b001;
    cmpWriteData <= 16'h0005;
    @(posedge clk);
    {cmpWriteFirst, cmpWriteSecond} <= 2'b01; // second below first
    cmpWriteData <= 16'h0003;
    @(posedge clk);
    {cmpWriteSecond, outEnable, firstMatchToggleEn} <= 3'b011;
    mode(2'b01);
    chk16(firstCapCmp, 16'h0005);
    chk16(16'(timerOutPin), 16'h0001);
    ticks(8);
    chk16(mainCount, 16'h0008);
    chk16(16'(timerOutPin), 16'h0000);
    chk16(16'(irq2Cnt), 16'h0001);
    // duty change while running: toggle on second match is already off
    cmpWriteSecond <= 1'b1;
    cmpWriteData <= 16'h0002;
    @(posedge clk);
    cmpWriteSecond <= 1'b0;
    ticks(1);
    secondMatchToggleEn <= 1'b1;
    @(posedge clk);
    secondMatchToggleEn <= 1'b0;
    chk16(secondCapCmp, 16'h0002);
    // capture run with the output unused; pin clear mode is not used
    mode(2'b00);
    {outEnable, firstMatchToggleEn} <= 2'b00;
    {firstCaptureMode, firstReverseSrc, secondCaptureMode} <= 3'b111;
    primaryEdgeSel <= EDGE_RISE;
    mode(2'b01);
    ticks(3);
    firePri <= 1'b1;
    @(posedge clk);
    firePri <= 1'b0;
    ticks(10);
    chkIn(secondCapCmp, 16'h0004, 16'h0007);
    chkIn(firstCapCmp, 16'h0009, 16'h000c);
    chk16(16'(irq2Cnt), 16'h0002);
    chk16(16'(irq1Cnt), 16'h0001);
    mode(2'b00);
    {firstReverseSrc, secondaryEdgeSel} <= {1'b0, EDGE_RISE};
    mode(2'b01);
    ticks(3);
    fireSec <= 1'b1;
    @(posedge clk);
    fireSec <= 1'b0;
    ticks(6);
    chkIn(firstCapCmp, 16'h0004, 16'h0007);
    chk16(16'(irq1Cnt), 16'h0002);
    // clear on first match at the top value, nonzero compares
    mode(2'b00);
    {firstCaptureMode, secondCaptureMode, cmpWriteFirst} <= 3'b001;
    cmpWriteData <= COUNT_MAX;
    @(posedge clk);
    cmpWriteFirst <= 1'b0;
    mode(2'b11);
    countTick <= 1'b1;
    repeat (65535) @(posedge clk);
    countTick <= 1'b0;
    @(posedge clk);
    chk16(mainCount, COUNT_MAX);
    ticks(1);
    chk16(mainCount, COUNT_RST);
    chk16(16'(wrapFlag), 16'h0001);
    clearWrap();
    chk16(16'(wrapFlag), 16'h0001);
    ticks(1);
    clearWrap();
    chk16(16'(wrapFlag), 16'h0000);
    wrap_up();
  end
  // about 66k cycles are needed; give room before calling it a hang
  initial begin
    #4000000;
    err_count++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
